// >>> inc/vdm_consts.vh
// constants for the vibration detection monitor: register map, fields, resets
`ifndef VDM_CONSTS_VH
`define VDM_CONSTS_VH
`define VDM_ADDR_CTRL      6'h00
`define VDM_ADDR_SENS      6'h04
`define VDM_ADDR_ROT_LVL   6'h08
`define VDM_ADDR_LIN_LVL   6'h0C
`define VDM_ADDR_STATUS    6'h10
`define VDM_ADDR_IRQ_STAT  6'h14
`define VDM_ADDR_IRQ_EN    6'h18
`define VDM_ADDR_IRQ_CLR   6'h1C
`define VDM_ADDR_INIT_CMD  6'h20
`define VDM_ADDR_LEARNED   6'h24
`define VDM_CTRL_SEL_LSB   0
`define VDM_CTRL_LINEAR    4
`define VDM_CTRL_WPROT     5
`define VDM_CTRL_MOTORLESS 6
`define VDM_SEL_NONE       4'h0
`define VDM_SEL_WARN       4'h1
`define VDM_SEL_ALARM      4'h2
`define VDM_SENS_MIN       16'h0032
`define VDM_SENS_MAX       16'h01F4
`define VDM_SENS_RESET     16'h0064
`define VDM_PCT_DIV        100
`define VDM_LVL_RESET      16'h0032
`define VDM_IRQ_WARN       0
`define VDM_IRQ_ALARM      1
`define VDM_IRQ_INIT_DONE  2
`define VDM_IRQ_INIT_REFUSE 3
`define VDM_INIT_CYCLES    16'h1000
`endif

// >>> design/vdm_monitor.v
// vibration detection monitor with wishbone register file and level learning
`timescale 1ns/1ps
`default_nettype none
`include "vdm_consts.vh"
module vdm_monitor #(
  parameter W          = 16,
  parameter INIT_CYCLES = 4096
) (
  input  wire          clock,
  input  wire          rst_n,
  input  wire          ctrl_tick,
  input  wire [W-1:0]  speed_fb,
  input  wire          wb_cyc_i,
  input  wire          wb_stb_i,
  input  wire          wb_we_i,
  input  wire [5:0]    wb_adr_i,
  input  wire [3:0]    wb_sel_i,
  input  wire [31:0]   wb_dat_i,
  output reg  [31:0]   wb_dat_o,
  output reg           wb_ack_o,
  output reg           vib_warning,
  output reg           vib_alarm,
  output wire          irq
);
  localparam ST_IDLE = 2'h0;
  localparam ST_RUN  = 2'h1;
  localparam ST_DONE = 2'h2;

  // register map, byte offsets on the six-bit address
  //   0x00 control, read and write
  //   0x04 sensitivity percent, read and write
  //   0x08 rotary level, read and write
  //   0x0C linear level, read and write
  //   0x10 live status, read only
  //   0x14 sticky event status, read only
  //   0x18 event enable, read and write
  //   0x1C event clear, write only
  //   0x20 learning start, write only
  //   0x24 learned level, read only
  //   anything else reads as zero
  //
  // control word layout
  //   [3:0] detection select
  //         0 no detection, both outputs low
  //         1 warning on detection
  //         2 alarm on detection
  //         3..15 detect nothing; outputs low from the next tick
  //   [4]   motor is linear, else rotary
  //   [5]   write prohibit, refuses learning start only
  //   [6]   motorless test active
  //   new select takes effect at once,
  //   no restart or reset needed
  //
  // sensitivity register
  //   percent, 50 to 500, one percent steps
  //   writes below 50 land as 50
  //   writes above 500 land as 500
  //   clamping keeps the threshold sane,
  //   software cannot read back a rejected value
  //   takes effect on the next control period
  //
  // level registers
  //   rotary level in speed units
  //   linear level in speed units of the linear axis
  //   both reset to a modest default
  //   writes ignored while learning runs,
  //   so the learned value is not torn
  //
  // live status layout
  //   [0] warning output
  //   [1] alarm output
  //   [2] magnitude above threshold now
  //   [3] learning busy
  //
  // sticky event bits, shared by status,
  // enable and clear registers
  //   [0] warning event
  //   [1] alarm event
  //   [2] learning finished
  //   [3] learning start refused
  //   irq is high while any enabled bit is set
  //
  // detection timing
  //   each control tick latches the magnitude of
  //   the speed difference to the previous tick
  //   the next tick compares it to the threshold
  //   outputs then stand for one control period
  //   a write of select 0 drops them next cycle
  //
  // band detector limitation
  //   a first difference only sees ripple that
  //   changes between ticks; slow drift and steady
  //   speed never trip it, which is the intent,
  //   but ripple near the tick rate aliases
  //
  // threshold arithmetic
  //   16 by 16 product kept at 32 bits,
  //   divide by 100 floors the result
  //   comparison is strictly greater than
  //   the divider is combinational; it costs
  //   area but keeps the answer in one period
  //
  // learning sequence
  //   start refused when writes are prohibited
  //   start refused when motorless test is on
  //   otherwise runs a fixed count of ticks,
  //   keeping the peak magnitude seen
  //   at the end the peak goes into the level
  //   of the motor type latched at start,
  //   and into the learned readback register
  //   operator must keep the motor turning fast
  //   enough, or the peak learned is too low
  //
  // bus timing
  //   request taken when cyc and stb are high
  //   and ack is low; ack follows one cycle later
  //   writes land at the taking edge
  //   read data stands only in the ack cycle
  //   writes need the two low byte lanes
  //
  // event clear
  //   write ones to clear; an event in the same
  //   cycle as its clear stays set, so no event
  //   is lost to a racing clear

  reg  [3:0]   vibration_detect_select;
  reg          motor_linear;
  reg          write_prohibit;
  reg          motorless_test_select;
  reg  [15:0]  vibration_sensitivity_pct;
  reg  [15:0]  rotary_vibration_level;
  reg  [15:0]  linear_vibration_level;
  reg  [15:0]  learned_level;
  reg  [3:0]   irq_stat;
  reg  [3:0]   irq_en;
  reg  [1:0]   init_state;
  reg  [15:0]  init_cnt;
  reg  [W-1:0] speed_prev;
  reg  [W-1:0] vib_mag;
  reg  [15:0]  peak;
  reg          init_busy_lin;

  wire         wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire         wb_wr  = wb_req & wb_we_i & wb_sel_i[0] & wb_sel_i[1];
  wire [15:0]  wdat16 = wb_dat_i[15:0];

  // band detector: first difference rejects steady speed, keeps fast ripple
  wire [W-1:0] diff     = speed_fb - speed_prev;
  wire [W-1:0] diff_abs = diff[W-1] ? (~diff + {{(W-1){1'b0}}, 1'b1}) : diff;

  // threshold = level * pct / 100, chosen by motor type
  wire [15:0]  base_lvl  = motor_linear ? linear_vibration_level : rotary_vibration_level;
  wire [31:0]  product   = base_lvl * vibration_sensitivity_pct;
  wire [31:0]  threshold = product / `VDM_PCT_DIV;
  wire         exceeded  = ({{(32-W){1'b0}}, vib_mag} > threshold);

  wire         det_warn  = ctrl_tick & exceeded & (vibration_detect_select == `VDM_SEL_WARN);
  wire         det_alarm = ctrl_tick & exceeded & (vibration_detect_select == `VDM_SEL_ALARM);

  wire         init_req    = wb_wr & (wb_adr_i == `VDM_ADDR_INIT_CMD) & wb_dat_i[0] & (init_state == ST_IDLE);
  wire         init_refuse = init_req & (write_prohibit | motorless_test_select);
  wire         init_done   = (init_state == ST_RUN) & ctrl_tick & (init_cnt == 16'h0001);

  wire [3:0]   ev = {init_refuse, init_done, det_alarm, det_warn};

  assign irq = |(irq_stat & irq_en);

  // magnitude of vibration component, updated once per control period
  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      speed_prev <= {W{1'b0}};
      vib_mag    <= {W{1'b0}};
    end
    else if (ctrl_tick)
    begin
      speed_prev <= speed_fb;
      vib_mag    <= diff_abs;
    end
  end

  // outputs follow detection per period; select 0 forces both low
  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      vib_warning <= 1'b0;
      vib_alarm   <= 1'b0;
    end
    else if (vibration_detect_select == `VDM_SEL_NONE)
    begin
      vib_warning <= 1'b0;
      vib_alarm   <= 1'b0;
    end
    else if (ctrl_tick)
    begin
      vib_warning <= det_warn;
      vib_alarm   <= det_alarm;
    end
  end

  // learning: track peak over a window of control periods, then store it
  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      init_state    <= ST_IDLE;
      init_cnt      <= 16'h0000;
      peak          <= 16'h0000;
      init_busy_lin <= 1'b0;
    end
    else
    begin
      case (init_state)
        ST_IDLE:
        begin
          if (init_req & ~init_refuse)
          begin
            init_state    <= ST_RUN;
            init_cnt      <= INIT_CYCLES[15:0];
            peak          <= 16'h0000;
            init_busy_lin <= motor_linear;
          end
        end
        ST_RUN:
        begin
          if (ctrl_tick)
          begin
            if ({{(32-W){1'b0}}, vib_mag} > {16'h0000, peak})
              peak <= vib_mag[15:0];
            init_cnt <= init_cnt - 16'h0001;
            if (init_cnt == 16'h0001)
              init_state <= ST_DONE;
          end
        end
        ST_DONE:
          init_state <= ST_IDLE;
        default:
          init_state <= ST_IDLE;
      endcase
    end
  end

  // register file; level writes blocked while learning owns them
  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      vibration_detect_select   <= `VDM_SEL_NONE;
      motor_linear              <= 1'b0;
      write_prohibit            <= 1'b0;
      motorless_test_select     <= 1'b0;
      vibration_sensitivity_pct <= `VDM_SENS_RESET;
      rotary_vibration_level    <= `VDM_LVL_RESET;
      linear_vibration_level    <= `VDM_LVL_RESET;
      learned_level             <= 16'h0000;
      irq_en                    <= 4'h0;
    end
    else
    begin
      if (wb_wr & (wb_adr_i == `VDM_ADDR_CTRL))
      begin
        vibration_detect_select <= wb_dat_i[3:0];
        motor_linear            <= wb_dat_i[`VDM_CTRL_LINEAR];
        write_prohibit          <= wb_dat_i[`VDM_CTRL_WPROT];
        motorless_test_select   <= wb_dat_i[`VDM_CTRL_MOTORLESS];
      end
      // out-of-range sensitivity is clamped rather than ignored
      if (wb_wr & (wb_adr_i == `VDM_ADDR_SENS))
        vibration_sensitivity_pct <= (wdat16 < `VDM_SENS_MIN) ? `VDM_SENS_MIN :
                                     (wdat16 > `VDM_SENS_MAX) ? `VDM_SENS_MAX : wdat16;
      if (wb_wr & (wb_adr_i == `VDM_ADDR_ROT_LVL) & (init_state == ST_IDLE))
        rotary_vibration_level <= wdat16;
      if (wb_wr & (wb_adr_i == `VDM_ADDR_LIN_LVL) & (init_state == ST_IDLE))
        linear_vibration_level <= wdat16;
      if (init_done)
      begin
        learned_level <= peak;
        if (init_busy_lin)
          linear_vibration_level <= peak;
        else
          rotary_vibration_level <= peak;
      end
      if (wb_wr & (wb_adr_i == `VDM_ADDR_IRQ_EN))
        irq_en <= wb_dat_i[3:0];
    end
  end

  // sticky events: set beats a same-cycle clear
  always @(posedge clock)
  begin
    if (!rst_n)
      irq_stat <= 4'h0;
    else if (wb_wr & (wb_adr_i == `VDM_ADDR_IRQ_CLR))
      irq_stat <= (irq_stat & ~wb_dat_i[3:0]) | ev;
    else
      irq_stat <= irq_stat | ev;
  end

  // one-wait-state slave: ack the cycle after the request
  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h00000000;
      if (wb_req & ~wb_we_i)
      begin
        case (wb_adr_i)
          `VDM_ADDR_CTRL:     wb_dat_o <= {25'h0000000, motorless_test_select, write_prohibit, motor_linear,
                                           vibration_detect_select};
          `VDM_ADDR_SENS:     wb_dat_o <= {16'h0000, vibration_sensitivity_pct};
          `VDM_ADDR_ROT_LVL:  wb_dat_o <= {16'h0000, rotary_vibration_level};
          `VDM_ADDR_LIN_LVL:  wb_dat_o <= {16'h0000, linear_vibration_level};
          `VDM_ADDR_STATUS:   wb_dat_o <= {28'h0000000, (init_state == ST_RUN), exceeded, vib_alarm, vib_warning};
          `VDM_ADDR_IRQ_STAT: wb_dat_o <= {28'h0000000, irq_stat};
          `VDM_ADDR_IRQ_EN:   wb_dat_o <= {28'h0000000, irq_en};
          `VDM_ADDR_LEARNED:  wb_dat_o <= {16'h0000, learned_level};
          default:            wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// >>> sim/vdm_speed_src.sv
// speed feedback source: control tick and rippling speed samples
`timescale 1ns/1ps
`default_nettype none
module vdm_speed_src (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic [15:0] amp,
  output var  logic        ctrl_tick,
  output var  logic [15:0] speed_fb
);
  logic [1:0] div;
  logic       sgn;
  // tick every four clocks; speed swings +amp/-amp so the ripple is 2*amp
  always @(posedge clock)
  begin
    div <= rst_n ? div + 2'h1 : 2'h0;
    ctrl_tick <= rst_n && div == 2'h3;
    sgn <= rst_n ? sgn ^ (div == 2'h3) : 1'h0;
    if (!rst_n || div == 2'h3)
      speed_fb <= !rst_n ? 16'h0 : sgn ? 16'h0 - amp : amp;
  end
endmodule
`default_nettype wire

// >>> sim/vdm_monitor_chk.sv
// port checker for the vibration detection monitor
`timescale 1ns/1ps
`default_nettype none
module vdm_chk (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        ctrl_tick,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        vib_warning,
  input wire logic        vib_alarm
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data off ack");
  a_dat_write: assert property (wb_ack_o && wb_we_i |-> wb_dat_o == 32'h0) else $error("data on write");
  a_one_event: assert property (!(vib_warning && vib_alarm)) else $error("warn and alarm");
  a_warn_tick: assert property ($rose(vib_warning) |-> $past(ctrl_tick)) else $error("warn off tick");
  a_alarm_tick: assert property ($rose(vib_alarm) |-> $past(ctrl_tick)) else $error("alarm off tick");
  // a warning only ends at a tick or just after a control write
  a_warn_fall: assert property ($fell(vib_warning) |-> $past(ctrl_tick) || $past(wb_ack_o && wb_we_i)
    || $past(wb_ack_o && wb_we_i, 2)) else $error("warn dropped");
endmodule
bind vdm_monitor vdm_chk u_chk (.clock(clock), .rst_n(rst_n), .ctrl_tick(ctrl_tick), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .vib_warning(vib_warning), .vib_alarm(vib_alarm));
`default_nettype wire

// >>> sim/vibration_detection_monitor_test.sv
// self-checking bench for the vibration detection monitor
`timescale 1ns/1ps
`default_nettype none
`include "vdm_consts.vh"
module vibration_detection_monitor_test;
  logic        clock, rst_n, cyc, stb, we, tick, ack, warn, alm, irq;
  logic [5:0]  adr;
  logic [15:0] amp, spd;
  logic [31:0] dat, rdat, q;
  int          fails, check_count, cnt;
  vdm_speed_src src (.clock(clock), .rst_n(rst_n), .amp(amp), .ctrl_tick(tick), .speed_fb(spd));
  vdm_monitor #(.INIT_CYCLES(4)) uut (.clock(clock), .rst_n(rst_n), .ctrl_tick(tick), .speed_fb(spd),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .vib_warning(warn), .vib_alarm(alm), .irq(irq));
  initial
  begin
    clock = 1'h0;
    forever #50 clock = ~clock;
  end
  task results;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] s, e);
    check_count++;
    if (s !== e)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  // one classic cycle, request held until ack is sampled
  task wb(input logic [5:0] a, input logic w, input logic [31:0] d);
    @(posedge clock);
    {cyc, stb, we, adr, dat} <= {2'h3, w, a, d};
    do @(posedge clock); while (ack !== 1'h1);
    q = rdat;
    {cyc, stb} <= 2'h0;
  endtask
  // four ticks let a speed step settle before judging
  task det(input logic [31:0] c, input logic [15:0] a, input logic e);
    wb(`VDM_ADDR_CTRL, 1'h1, c);
    amp <= a;
    repeat (16) @(posedge clock);
    chk("warning", warn, e);
  endtask
  task t_sel;
    for (int s = 0; s < 4; s++)
    begin
      det(s, 16'h001E, s == 1);
      chk("alarm", alm, s == 2);
    end
  endtask
  task t_sens;
    logic [15:0] sv [7] = '{16'h0064, 16'h0064, 16'h0078, 16'h0078, 16'h0032, 16'h01F4, 16'h01F4};
    logic [15:0] av [7] = '{16'h0019, 16'h001A, 16'h001E, 16'h001F, 16'h000D, 16'h007D, 16'h007E};
    logic [6:0]  ev = 7'h5A;
    for (int i = 0; i < 7; i++)
    begin
      wb(`VDM_ADDR_SENS, 1'h1, sv[i]);
      det(32'h1, av[i], ev[i]);
    end
    wb(`VDM_ADDR_SENS, 1'h1, 32'h3E8);
    wb(`VDM_ADDR_SENS, 1'h0, 32'h0);
    chk("sens max", q, 32'h1F4);
    wb(`VDM_ADDR_SENS, 1'h1, 32'h31);
    wb(`VDM_ADDR_SENS, 1'h0, 32'h0);
    chk("sens min", q, 32'h32);
    wb(`VDM_ADDR_SENS, 1'h1, 32'h64);
  endtask
  task t_lin;
    wb(`VDM_ADDR_LIN_LVL, 1'h1, 32'h14);
    wb(`VDM_ADDR_ROT_LVL, 1'h1, 32'hC8);
    det(32'h11, 16'h000B, 1'h1);
    det(32'h11, 16'h000A, 1'h0);
    det(32'h01, 16'h000B, 1'h0);
    wb(`VDM_ADDR_ROT_LVL, 1'h1, 32'h32);
  endtask
  task t_irq;
    det(32'h1, 16'h001E, 1'h1);
    for (int m = 1; m >= 0; m--)
    begin
      wb(`VDM_ADDR_IRQ_EN, 1'h1, m);
      @(posedge clock);
      chk("irq mask", irq, m);
    end
    wb(`VDM_ADDR_IRQ_EN, 1'h1, 32'h1);
    amp <= 16'h0;
    repeat (16) @(posedge clock);
    wb(`VDM_ADDR_IRQ_CLR, 1'h1, 32'hF);
    @(posedge clock);
    chk("irq clear", irq, 1'h0);
  endtask
  task t_learn;
    for (int i = 0; i < 2; i++)
    begin
      wb(`VDM_ADDR_CTRL, 1'h1, i ? 32'h41 : 32'h21);
      wb(`VDM_ADDR_INIT_CMD, 1'h1, 32'h1);
      wb(`VDM_ADDR_IRQ_STAT, 1'h0, 32'h0);
      chk("refused", q[3], 1'h1);
      wb(`VDM_ADDR_IRQ_CLR, 1'h1, 32'hF);
    end
    det(32'h0, 16'h0028, 1'h0);
    wb(`VDM_ADDR_INIT_CMD, 1'h1, 32'h1);
    do wb(`VDM_ADDR_STATUS, 1'h0, 32'h0); while (q[3] !== 1'h0);
    wb(`VDM_ADDR_ROT_LVL, 1'h0, 32'h0);
    chk("learned level", q, 32'h50);
    wb(`VDM_ADDR_LEARNED, 1'h0, 32'h0);
    chk("learned back", q, 32'h50);
    wb(`VDM_ADDR_IRQ_STAT, 1'h0, 32'h0);
    chk("learn done event", q[2], 1'h1);
  endtask
  // hang guard
  always @(posedge clock)
  begin
    cnt <= cnt + 1;
    if (cnt == 4000)
    begin
      fails++;
      results;
    end
  end
  initial
  begin
    {rst_n, cyc, stb, we, adr, dat, amp} = 0;
    repeat (4) @(posedge clock);
    rst_n <= 1'h1;
    wb(`VDM_ADDR_SENS, 1'h0, 32'h0);
    chk("sens reset", q, 32'h64);
    wb(6'h3C, 1'h0, 32'h0);
    chk("unmapped", q, 32'h0);
    t_sel;
    t_sens;
    t_lin;
    t_irq;
    t_learn;
    results;
  end
endmodule
`default_nettype wire
